//--- rtl/lvd_pkg.sv
// Shared constants for the low-voltage detect controller
package lvd_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00; // low_voltage_control
    localparam logic [7:0] STATUS_OFFSET = 8'h04; // flag and interrupt enables

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int unsigned TRIP_LSB   = 0;     // trip_level_select low bit
    localparam int unsigned TRIP_W     = 4;     // trip_level_select width
    localparam int unsigned PWR_BIT    = 4;     // detect_power_enable
    localparam int unsigned STABLE_BIT = 5;     // reference_stable_flag (read only)
    localparam logic [3:0]  TRIP_RESET    = 4'h5; // Trip code after reset
    localparam logic [3:0]  TRIP_EXTERNAL = 4'hF; // Comparator fed from pin
    localparam logic [3:0]  TRIP_RESERVED = 4'h0; // Unused code

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_BIT  = 0;      // low_voltage_flag, write one to clear
    localparam int unsigned LVIE_BIT  = 1;      // low_voltage_int_enable
    localparam int unsigned GLOB_EN_BIT = 2;    // global_int_enable
    localparam int unsigned SLEEP_BIT = 3;      // Sleep state seen (read only)

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 8;     // 125 MHz system clock
    localparam int unsigned REF_STARTUP_NS = 20000; // Reference settling time
    localparam int unsigned REF_STARTUP_CYCLES =
        (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_CNT_W = 12;     // Holds REF_STARTUP_CYCLES

    // ------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reference start-up states
    typedef enum logic [1:0] {
        REF_OFF,
        REF_SETTLING,
        REF_STABLE
    } ref_state_e;

endpackage : lvd_pkg

//--- rtl/lvd_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
module lvd_pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;   // First stage, read only by second
    logic [WIDTH-1:0] sync2_q;  // Second stage
    logic [WIDTH-1:0] sync3_q;  // Third stage
    logic [WIDTH-1:0] level_q;  // Accepted level

    // Shift chain, frozen while clock enable is low
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q  <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else if (i_clk_en) begin
            meta_q  <= i_async;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
        end
    end

    // Each bit changes only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    level_q[g] <= 1'b0;
                end else if (i_clk_en && (sync2_q[g] == sync3_q[g])) begin
                    level_q[g] <= sync3_q[g];
                end
            end
        end
    endgenerate

    assign o_level = level_q;

endmodule : lvd_pin_sync

//--- rtl/lvd_ctrl.sv
// Low-voltage detect control, flag logic and AXI4-Lite register slave
//
// Operation
// - Flag sets on trip while detector enabled
// - Four-bit trip code selects trip point
// - Code 1111 feeds comparator from external pin
// - Codes 0001-1110 pick taps; 0000 reserved
// - Power bit powers comparator and divider
// - Stable flag reads one once reference settled
// - No flag before reference is stable
// - Start-up delay is 2500 enabled clock cycles, 20 us only at 125 MHz
// - Enabled flag requests jump to interrupt vector
// - Detector runs in Sleep, trip wakes device
// - Vector after wake only if globally enabled
// - Reset returns control register, detector off
// - Control bits 7-6 read zero, ignore writes
module lvd_ctrl #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_clk_en,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    // Analog front end
    input  wire logic              i_divider_below,
    input  wire logic              i_external_trip_input_below,
    output logic                   o_detect_power,
    output logic [3:0]             o_tap_select,
    output logic                   o_external_trip_select,
    // Core interface
    input  wire logic              i_sleep,
    output logic                   o_wake,
    output logic                   o_vector_req
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Word address match against a register offset
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0]        offset);
        addr_hit = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
    endfunction : addr_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0]          trip_q;         // trip_level_select
    logic                pwr_q;          // detect_power_enable
    logic                flag_q;         // low_voltage_flag
    logic                flag_d;
    logic                lvie_q;         // low_voltage_int_enable
    logic                glob_en_q;      // global_int_enable
    logic                wake_q;         // Wake request to core
    logic                vector_q;       // Interrupt vector request
    lvd_pkg::ref_state_e ref_state_q;    // Reference start-up state
    lvd_pkg::ref_state_e ref_state_d;
    logic [lvd_pkg::STARTUP_CNT_W-1:0] startup_cnt_q; // Settling counter
    logic [lvd_pkg::STARTUP_CNT_W-1:0] startup_cnt_d;

    // Bus holding registers
    logic              aw_hold_q;        // Write address captured
    logic [ADDR_W-1:0] awaddr_q;
    logic              w_hold_q;         // Write data captured
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // ------------------------------------------------------------------
    // Comparator input synchronisation
    // ------------------------------------------------------------------
    logic [1:0] below_sync;              // [0] divider, [1] external pin

    lvd_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_external_trip_input_below, i_divider_below}),
        .o_level   (below_sync)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    localparam logic [lvd_pkg::STARTUP_CNT_W-1:0] STARTUP_LAST =
        lvd_pkg::STARTUP_CNT_W'(lvd_pkg::REF_STARTUP_CYCLES - 1);

    wire ext_sel     = (trip_q == lvd_pkg::TRIP_EXTERNAL);
    wire trip_valid  = (trip_q != lvd_pkg::TRIP_RESERVED);
    wire sel_below   = ext_sel ? below_sync[1] : below_sync[0];
    wire ref_stable  = (ref_state_q == lvd_pkg::REF_STABLE);
    // Trip only counts while powered, settled and on a usable code
    wire detect      = pwr_q && ref_stable && trip_valid && sel_below;

    wire wr_go       = aw_hold_q && w_hold_q && !bvalid_q;
    wire wr_ctrl     = wr_go && addr_hit(awaddr_q, lvd_pkg::CTRL_OFFSET);
    wire wr_status   = wr_go && addr_hit(awaddr_q, lvd_pkg::STATUS_OFFSET);
    wire wr_lane0    = wstrb_q[0];
    wire flag_clr    = wr_status && wr_lane0 && wdata_q[lvd_pkg::FLAG_BIT];
    wire ar_take     = i_s_axi_arvalid && !rvalid_q;
    wire rd_ctrl     = addr_hit(i_s_axi_araddr, lvd_pkg::CTRL_OFFSET);
    wire rd_status   = addr_hit(i_s_axi_araddr, lvd_pkg::STATUS_OFFSET);

    // Control word: bits 7-6 always zero
    wire [31:0] ctrl_word = {26'h0, ref_stable, pwr_q, trip_q};
    wire [31:0] stat_word = {28'h0, i_sleep, glob_en_q, lvie_q, flag_q};

    // ------------------------------------------------------------------
    // Reference start-up timer
    // ------------------------------------------------------------------

    // Settling counted in cycles derived from a fixed time
    always_comb begin
        ref_state_d   = ref_state_q;
        startup_cnt_d = startup_cnt_q;
        case (ref_state_q)
            lvd_pkg::REF_OFF: begin
                startup_cnt_d = '0;
                if (pwr_q) begin
                    ref_state_d = lvd_pkg::REF_SETTLING;
                end
            end
            lvd_pkg::REF_SETTLING: begin
                if (!pwr_q) begin
                    ref_state_d = lvd_pkg::REF_OFF;
                end else if (startup_cnt_q == STARTUP_LAST) begin
                    ref_state_d = lvd_pkg::REF_STABLE;
                end else begin
                    startup_cnt_d = startup_cnt_q + 1'b1;
                end
            end
            lvd_pkg::REF_STABLE: begin
                if (!pwr_q) begin
                    ref_state_d = lvd_pkg::REF_OFF;
                end
            end
            default: begin
                ref_state_d = lvd_pkg::REF_OFF;
            end
        endcase
    end

    // Timer registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_state_q   <= lvd_pkg::REF_OFF;
            startup_cnt_q <= '0;
        end else if (i_clk_en) begin
            ref_state_q   <= ref_state_d;
            startup_cnt_q <= startup_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------------

    // Trip event wins over a clear in the same cycle
    assign flag_d = detect || (flag_q && !flag_clr);

    // Software fields and flag
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trip_q <= lvd_pkg::TRIP_RESET;
            pwr_q  <= 1'b0;
            lvie_q <= 1'b0;
            glob_en_q <= 1'b0;
            flag_q <= 1'b0;
        end else if (i_clk_en) begin
            flag_q <= flag_d;
            // Only the low byte holds fields
            if (wr_ctrl && wr_lane0) begin
                trip_q <= wdata_q[lvd_pkg::TRIP_LSB +: lvd_pkg::TRIP_W];
                pwr_q  <= wdata_q[lvd_pkg::PWR_BIT];
            end
            if (wr_status && wr_lane0) begin
                lvie_q <= wdata_q[lvd_pkg::LVIE_BIT];
                glob_en_q <= wdata_q[lvd_pkg::GLOB_EN_BIT];
            end
        end
    end

    // Wake and vector requests to the core
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wake_q   <= 1'b0;
            vector_q <= 1'b0;
        end else if (i_clk_en) begin
            wake_q   <= i_sleep && flag_d;
            vector_q <= flag_d && lvie_q && glob_en_q;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------

    // Address and data captured in either order, answered together
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= lvd_pkg::RESP_OKAY;
        end else if (i_clk_en) begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata;
                wstrb_q  <= i_s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                // Unmapped address gets an error
                bresp_q   <= (wr_ctrl || wr_status) ? lvd_pkg::RESP_OKAY
                                                    : lvd_pkg::RESP_SLVERR;
            end else if (bvalid_q && i_s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------

    // One read in flight, data from a register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= lvd_pkg::RESP_OKAY;
        end else if (i_clk_en) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_ctrl ? ctrl_word :
                            (rd_status ? stat_word : 32'h0000_0000);
                rresp_q  <= (rd_ctrl || rd_status) ? lvd_pkg::RESP_OKAY
                                                   : lvd_pkg::RESP_SLVERR;
            end else if (rvalid_q && i_s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_s_axi_awready       = !aw_hold_q && !bvalid_q && i_clk_en;
    assign o_s_axi_wready        = !w_hold_q && !bvalid_q && i_clk_en;
    assign o_s_axi_bvalid        = bvalid_q;
    assign o_s_axi_bresp         = bresp_q;
    assign o_s_axi_arready       = !rvalid_q && i_clk_en;
    assign o_s_axi_rvalid        = rvalid_q;
    assign o_s_axi_rdata         = rdata_q;
    assign o_s_axi_rresp         = rresp_q;
    assign o_detect_power        = pwr_q;
    assign o_tap_select          = trip_q;
    assign o_external_trip_select = ext_sel;
    assign o_wake                = wake_q;
    assign o_vector_req          = vector_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    flag_sets_a: assert property (i_clk_en && detect |=> flag_q)
        else $error("flag did not set on trip");

    ext_route_a: assert property (o_external_trip_select == (o_tap_select == 4'hF))
        else $error("external input routing wrong");

    reserved_code_a: assert property (i_clk_en && trip_q == 4'h0 && !flag_q |=> !flag_q)
        else $error("reserved code raised flag");

    unpowered_a: assert property (!pwr_q |-> !ref_stable)
        else $error("stable flag without power");

    early_flag_a: assert property (i_clk_en && !ref_stable && !flag_q |=> !flag_q)
        else $error("flag before reference stable");

    startup_time_a: assert property ($rose(ref_stable) |-> $past(startup_cnt_q) == STARTUP_LAST)
        else $error("start-up delay wrong");

    vector_req_a: assert property (i_clk_en && flag_q && !flag_clr && lvie_q && glob_en_q
                                   |=> o_vector_req)
        else $error("vector request missing");

    sleep_wake_a: assert property (i_clk_en && flag_q && !flag_clr && i_sleep |=> o_wake)
        else $error("wake missing");

    no_vector_a: assert property (i_clk_en && !glob_en_q |=> !o_vector_req)
        else $error("vector without global enable");

    upper_zero_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[7:6] == 2'h0)
        else $error("upper control bits not zero");

    sticky_flag_a: assert property (i_clk_en && flag_q && !flag_clr |=> flag_q)
        else $error("flag dropped without clear");

    cover_stable_c: cover property ($rose(ref_stable));
    cover_flag_c:   cover property ($rose(flag_q) && ext_sel);
    cover_wake_c:   cover property ($rose(o_wake));
    cover_vector_c: cover property ($rose(o_vector_req));

endmodule : lvd_ctrl

//--- test/lvd_ctrl_tb.sv
// Self-checking bench for the low-voltage detect controller
module lvd_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------------
    // Bench signals
    // ----------------------------------------------------------------------
    logic        clk;          // 125 MHz system clock
    logic        rstn;         // Active-low reset
    logic [7:0]  awaddr;       // Write address
    logic        awvalid;      // Write address valid
    logic        awready;      // Write address ready
    logic [31:0] wdata;        // Write data
    logic        wvalid;       // Write data valid
    logic        wready;       // Write data ready
    logic [1:0]  bresp;        // Write response
    logic        bvalid;       // Write response valid
    logic        bready;       // Write response ready
    logic [7:0]  araddr;       // Read address
    logic        arvalid;      // Read address valid
    logic        arready;      // Read address ready
    logic [31:0] rdata;        // Read data
    logic [1:0]  rresp;        // Read response
    logic        rvalid;       // Read data valid
    logic        rready;       // Read data ready
    logic        div_below;    // Divider comparator result
    logic        ext_below;    // External pin comparator result
    logic        pwr;          // Detector power output
    logic [3:0]  tap;          // Selected divider tap
    logic        ext_sel;      // External input selected
    logic        sleep;        // Core asleep
    logic        wake;         // Wake request
    logic        vec;          // Vector request
    int          bad_count;       // Mismatches seen
    int          samples_checked; // Comparisons made

    // ----------------------------------------------------------------------
    // Device under test
    // ----------------------------------------------------------------------
    lvd_ctrl dut (.i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_divider_below(div_below),
        .i_external_trip_input_below(ext_below), .o_detect_power(pwr),
        .o_tap_select(tap), .o_external_trip_select(ext_sel), .i_sleep(sleep),
        .o_wake(wake), .o_vector_req(vec));

    // ----------------------------------------------------------------------
    // Clock generator
    // ----------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Compare one value
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Idle cycles
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) begin
            bad_count++;
            results();
        end
        check("bresp", 32'(er), 32'(bresp));
    endtask : wr

    // Bus read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) begin
            bad_count++;
            results();
        end
        check("rdata", e, rdata);
        check("rresp", 32'(er), 32'(rresp));
    endtask : rd

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, div_below, ext_below, sleep} = '0;
        bad_count = 0;
        samples_checked = 0;
        idle(5);
        rstn <= 1'b1;
        @(posedge clk);
        // Reset state of both registers and the power output
        rd(lvd_pkg::CTRL_OFFSET, 32'h05, lvd_pkg::RESP_OKAY);
        rd(lvd_pkg::STATUS_OFFSET, 32'h00, lvd_pkg::RESP_OKAY);
        check("power", 32'h0, 32'(pwr));
        // Upper bits and stable bit ignore writes, pin routed in code 1111
        ext_below <= 1'b1;
        wr(lvd_pkg::CTRL_OFFSET, 32'hFF, lvd_pkg::RESP_OKAY);
        rd(lvd_pkg::CTRL_OFFSET, 32'h1F, lvd_pkg::RESP_OKAY);
        check("power", 32'h1, 32'(pwr));
        check("ext_sel", 32'h1, 32'(ext_sel));
        // Still settling shortly before the start-up time: no flag
        idle(lvd_pkg::REF_STARTUP_CYCLES - 100);
        rd(lvd_pkg::CTRL_OFFSET, 32'h1F, lvd_pkg::RESP_OKAY);
        rd(lvd_pkg::STATUS_OFFSET, 32'h00, lvd_pkg::RESP_OKAY);
        ext_below <= 1'b0;
        div_below <= 1'b1;
        idle(150);
        rd(lvd_pkg::CTRL_OFFSET, 32'h3F, lvd_pkg::RESP_OKAY);
        rd(lvd_pkg::STATUS_OFFSET, 32'h00, lvd_pkg::RESP_OKAY);
        // Trip from the external pin sets the flag
        ext_below <= 1'b1;
        idle(8);
        rd(lvd_pkg::STATUS_OFFSET, 32'h01, lvd_pkg::RESP_OKAY);
        wr(lvd_pkg::STATUS_OFFSET, 32'h06, lvd_pkg::RESP_OKAY);
        // Vector request is registered one edge after the enables land
        idle(1);
        check("vector", 32'h1, 32'(vec));
        sleep <= 1'b1;
        idle(3);
        check("wake", 32'h1, 32'(wake));
        sleep <= 1'b0;
        ext_below <= 1'b0;
        idle(8);
        rd(lvd_pkg::STATUS_OFFSET, 32'h07, lvd_pkg::RESP_OKAY);
        wr(lvd_pkg::STATUS_OFFSET, 32'h03, lvd_pkg::RESP_OKAY);
        rd(lvd_pkg::STATUS_OFFSET, 32'h02, lvd_pkg::RESP_OKAY);
        check("vector", 32'h0, 32'(vec));
        // Wake without global enable gives no vector
        sleep <= 1'b1;
        ext_below <= 1'b1;
        idle(8);
        check("wake", 32'h1, 32'(wake));
        check("vector", 32'h0, 32'(vec));
        sleep <= 1'b0;
        ext_below <= 1'b0;
        idle(8);
        wr(lvd_pkg::STATUS_OFFSET, 32'h01, lvd_pkg::RESP_OKAY);
        // Every internal tap code reaches the divider select
        for (int c = 1; c < 15; c++) begin
            wr(lvd_pkg::CTRL_OFFSET, 32'h10 | c, lvd_pkg::RESP_OKAY);
            check("tap", 32'(c), 32'(tap));
            check("ext_sel", 32'h0, 32'(ext_sel));
        end
        // Reserved code never trips
        wr(lvd_pkg::CTRL_OFFSET, 32'h10, lvd_pkg::RESP_OKAY);
        // Drop the flag left by the tap sweep, divider still below
        wr(lvd_pkg::STATUS_OFFSET, 32'h01, lvd_pkg::RESP_OKAY);
        idle(lvd_pkg::REF_STARTUP_CYCLES + 20);
        rd(lvd_pkg::STATUS_OFFSET, 32'h00, lvd_pkg::RESP_OKAY);
        // Unmapped address refused both ways
        wr(8'h08, 32'hFF, lvd_pkg::RESP_SLVERR);
        rd(8'h08, 32'h00, lvd_pkg::RESP_SLVERR);
        // Reset in mid-run turns the detector off
        rstn <= 1'b0;
        idle(5);
        rstn <= 1'b1;
        @(posedge clk);
        check("power", 32'h0, 32'(pwr));
        rd(lvd_pkg::CTRL_OFFSET, 32'h05, lvd_pkg::RESP_OKAY);
        results();
    end
endmodule : lvd_ctrl_tb
